// [shared/acc_map.svh]
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_EN      7'h61
`define ACC_IDX_CFG_A   7'h62
`define ACC_IDX_CFG_C   7'h64
`define ACC_IDX_AVG     7'h68
`define ACC_IDX_STATE   7'h6A
`define ACC_IDX_PIN     7'h6B
`define ACC_IDX_SWTRIG  7'h6C
`define ACC_IDX_LINK    7'h71

// Reset values
`define ACC_RST_EN      8'h01
`define ACC_RST_CFG_A   8'h01
`define ACC_RST_CFG_C   8'h02
`define ACC_RST_AVG     8'h61
`define ACC_RST_PIN     8'h00
`define ACC_RST_SWTRIG  8'h01
`define ACC_RST_LINK    8'h00

// Field positions
`define ACC_EN_BIT      0
`define ACC_FG_BIT      0
`define ACC_BG_BIT      1
`define ACC_OS_BIT      2
`define ACC_BGOS_BIT    3
`define ACC_PARK_HI     1
`define ACC_PARK_LO     0
`define ACC_OSAVG_HI    6
`define ACC_OSAVG_LO    4
`define ACC_LINAVG_HI   2
`define ACC_LINAVG_LO   0
`define ACC_TSRC_BIT    0
`define ACC_STSEL_HI    2
`define ACC_STSEL_LO    1
`define ACC_SWTRIG_BIT  0
`define ACC_LINK_BIT    0

// Status register layout
`define ACC_ST_FG_BIT   0
`define ACC_ST_STOP_BIT 1
`define ACC_ST_CODE_LO  2

// Status pin selection codes
`define ACC_SEL_FG      2'h0
`define ACC_SEL_STOP    2'h1
`define ACC_SEL_ALARM   2'h2

// Parked core codes
`define ACC_PARK_C0     2'h0
`define ACC_PARK_C1     2'h1
`define ACC_PARK_C2     2'h2

// Timing: one averaging step, shifted by the depth code
`define ACC_CLK_NS      10
`define ACC_STEP_NS     160
`define ACC_STEP_CYC    (`ACC_STEP_NS / `ACC_CLK_NS)

`endif

// [shared/acc_pkg.sv]
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_HOLD,
        ACC_CLEAR,
        ACC_WAIT,
        ACC_FG_OS,
        ACC_FG_LIN,
        ACC_BG_RUN,
        ACC_BG_STOP,
        ACC_DONE
    } acc_state_t;

    typedef logic [7:0] acc_byte_t;
endpackage

// [shared/acc_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface acc_cfg_if;
    // Towards the sequencer
    logic       cal_en;
    logic       trig;
    logic       fg_sel;
    logic       bg_en;
    logic       os_en;
    logic       bgos_en;
    logic [1:0] park_sel;
    logic [2:0] offset_averaging_depth;
    logic [2:0] lin_avg;
    // Back from the sequencer
    logic       foreground_done_flag;
    logic       stopped;
    logic [2:0] code;
    logic       clr_vals;
    logic       os_run;
    logic       lin_run;
    logic       bgos_run;
    logic [2:0] park;

    modport top (output cal_en, trig, fg_sel, bg_en, os_en, bgos_en, park_sel,
                 offset_averaging_depth, lin_avg,
                 input  foreground_done_flag, stopped, code, clr_vals, os_run, lin_run,
                 bgos_run, park);
    modport seq (input  cal_en, trig, fg_sel, bg_en, os_en, bgos_en, park_sel,
                 offset_averaging_depth, lin_avg,
                 output foreground_done_flag, stopped, code, clr_vals, os_run, lin_run,
                 bgos_run, park);
endinterface
`default_nettype wire

// [src/acc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// [src/acc_cal_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_cal_seq #(
    parameter int CW = 13
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    // Configuration and status
    acc_cfg_if.seq    cfg
);
    import acc_pkg::*;

    acc_state_t    st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          en_q, en_d;
    logic          fg_q, fg_d, bg_q, bg_d, os_q, os_d, bgos_q, bgos_d;
    logic [1:0]    park_q, park_d;
    logic [2:0]    osa_q, osa_d, lina_q, lina_d;
    logic          done_q, done_d, stop_q, stop_d, clr_q, clr_d;
    logic [2:0]    pk_q, pk_d;
    logic          osr_q, osr_d, linr_q, linr_d, bgosr_q, bgosr_d;

    function automatic logic [CW-1:0] depth_cyc(input logic [2:0] d);
        depth_cyc = CW'(`ACC_STEP_CYC) << d;
    endfunction

    function automatic acc_state_t after_fg(input logic bg, input logic t);
        if (!bg)
            after_fg = ACC_DONE;
        else if (t)
            after_fg = ACC_BG_RUN;
        else
            after_fg = ACC_BG_STOP;
    endfunction

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        en_d   = cfg.cal_en;
        fg_d   = fg_q;
        bg_d   = bg_q;
        os_d   = os_q;
        bgos_d = bgos_q;
        park_d = park_q;
        osa_d  = osa_q;
        lina_d = lina_q;
        done_d = done_q;
        clr_d  = 1'b0;
        // Settings are captured at the enable edge only
        if (cfg.cal_en && !en_q) begin
            fg_d   = cfg.fg_sel;
            bg_d   = cfg.bg_en;
            os_d   = cfg.os_en;
            bgos_d = cfg.bgos_en;
            park_d = cfg.park_sel;
            osa_d  = cfg.offset_averaging_depth;
            lina_d = cfg.lin_avg;
        end
        case (st_q)
            ACC_HOLD: begin
                done_d = 1'b0;
                if (cfg.cal_en && !en_q) begin
                    st_d  = ACC_CLEAR;
                    clr_d = 1'b1;
                end
            end
            ACC_CLEAR: begin
                if (fg_q) begin
                    st_d = ACC_WAIT;
                end else begin
                    done_d = 1'b1;
                    st_d   = after_fg(bg_q, cfg.trig);
                    // Background may follow at once; load a full phase
                    cnt_d  = depth_cyc(lina_q);
                end
            end
            ACC_WAIT: begin
                if (cfg.trig) begin
                    st_d  = os_q ? ACC_FG_OS : ACC_FG_LIN;
                    cnt_d = os_q ? depth_cyc(osa_q) : depth_cyc(lina_q);
                end
            end
            ACC_FG_OS: begin
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    st_d  = ACC_FG_LIN;
                    cnt_d = depth_cyc(lina_q);
                end
            end
            ACC_FG_LIN: begin
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    done_d = 1'b1;
                    st_d   = after_fg(bg_q, cfg.trig);
                    cnt_d  = depth_cyc(lina_q);
                end
            end
            ACC_BG_RUN: begin
                // Halts only at the end of a phase
                cnt_d = cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    cnt_d = depth_cyc(lina_q);
                    if (!cfg.trig)
                        st_d = ACC_BG_STOP;
                end
            end
            ACC_BG_STOP: begin
                if (cfg.trig) begin
                    st_d  = ACC_BG_RUN;
                    cnt_d = depth_cyc(lina_q);
                end
            end
            ACC_DONE: begin
                st_d = ACC_DONE;
            end
            default: begin
                st_d = ACC_HOLD;
            end
        endcase
        if (!cfg.cal_en) begin
            st_d   = ACC_HOLD;
            done_d = 1'b0;
        end
        stop_d = (st_d == ACC_BG_STOP) || (st_d == ACC_DONE);
        // Phase outputs registered with the state, no decode at the pins
        osr_d   = (st_d == ACC_FG_OS);
        linr_d  = (st_d == ACC_FG_LIN) || (st_d == ACC_BG_RUN);
        bgosr_d = (st_d == ACC_BG_RUN) && bg_d && bgos_d;
        pk_d = 3'h0;
        if (!bg_d && st_d != ACC_HOLD) begin
            case (park_d)
                `ACC_PARK_C0: pk_d = 3'h1;
                `ACC_PARK_C1: pk_d = 3'h2;
                `ACC_PARK_C2: pk_d = 3'h4;
                default:      pk_d = 3'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_q   <= ACC_HOLD;
            cnt_q  <= '0;
            en_q   <= 1'b0;
            fg_q   <= 1'b1;
            bg_q   <= 1'b0;
            os_q   <= 1'b0;
            bgos_q <= 1'b0;
            park_q <= 2'h2;
            osa_q  <= 3'h6;
            lina_q <= 3'h1;
            done_q <= 1'b0;
            stop_q <= 1'b0;
            clr_q  <= 1'b0;
            pk_q   <= 3'h0;
            osr_q  <= 1'b0;
            linr_q <= 1'b0;
            bgosr_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            en_q   <= en_d;
            fg_q   <= fg_d;
            bg_q   <= bg_d;
            os_q   <= os_d;
            bgos_q <= bgos_d;
            park_q <= park_d;
            osa_q  <= osa_d;
            lina_q <= lina_d;
            done_q <= done_d;
            stop_q <= stop_d;
            clr_q  <= clr_d;
            pk_q   <= pk_d;
            osr_q  <= osr_d;
            linr_q <= linr_d;
            bgosr_q <= bgosr_d;
        end
    end

    assign cfg.foreground_done_flag  = done_q;
    assign cfg.stopped  = stop_q;
    assign cfg.code     = st_q;
    assign cfg.clr_vals = clr_q;
    assign cfg.os_run   = osr_q;
    assign cfg.lin_run  = linr_q;
    assign cfg.bgos_run = bgosr_q;
    assign cfg.park     = pk_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence en_rise_s;
        cfg.cal_en && !en_q;
    endsequence
    sequence cleared_s;
        st_q == ACC_CLEAR && clr_q;
    endsequence

    clear_on_start_a: assert property (en_rise_s |=> cleared_s)
        else $error("calibration values not reset at start");
    bg_offset_gate_a: assert property (cfg.bgos_run |-> bg_q && bgos_q)
        else $error("background offset ran without its enables");
    fg_offset_gate_a: assert property (st_q == ACC_FG_OS |-> os_q && fg_q)
        else $error("foreground offset ran without its enables");
    skip_foreground_done_flag_a: assert property (cleared_s and !fg_q && cfg.cal_en |=> done_q && !cfg.os_run)
        else $error("skipped foreground did not flag done");
    stop_no_bg_a: assert property (done_q && !bg_q && cfg.cal_en |=> stop_q)
        else $error("stopped flag missing with background off");
    resume_clear_a: assert property (st_q == ACC_BG_RUN |-> !stop_q)
        else $error("stopped flag high while running");
    hold_reset_a: assert property (!cfg.cal_en |=> st_q == ACC_HOLD && !stop_q && !done_q)
        else $error("calibration not held in reset");
    park_bg_off_a: assert property (pk_q != 3'h0 |-> !bg_q && $onehot(pk_q))
        else $error("core parked while background on or several parked");
    bg_off_run_a: assert property (!bg_q |-> st_q != ACC_BG_RUN)
        else $error("background ran while disabled");
endmodule
`default_nettype wire

// [src/acc_top.sv]
//
// Overview of operation
// - Background offset needs background-offset and background enables
// - Foreground offset needs offset and foreground enables
// - Background enable bit runs continuous calibration
// - Start clears values, then optional foreground run
// - Parked-core field picks the idle sub-core while background is off
// - Offset averaging depth from bits six to four
// - Linearity averaging depth from bits two to zero
// - Read-only status carries three-bit state code
// - Stopped flag follows background halt and resume
// - Background off: stopped once foreground ends
// - Foreground-done flag high after completion or skip
// - Status pin select: done, stopped, alarm, low
// - Source bit zero uses the software trigger
// - Source bit one uses the hardware pin
// - Enable starts calibration; clear holds it, dividers
// - Software trigger behaves like the pin, two cycles sooner (no synchronizer)
//
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_top (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Pins
    input  wire logic        hardware_trigger_pin_i,
    input  wire logic        alarm_i,
    output logic             status_output_pin_o,
    // Converter side
    output logic             serial_link_enable_o,
    output logic             divider_reset_o,
    output logic             cal_values_reset_o,
    output logic             offset_run_o,
    output logic             linearity_run_o,
    output logic             background_offset_run_o,
    output logic [2:0]       core_park_o,
    output logic [2:0]       offset_averaging_depth_o,
    output logic [2:0]       linearity_averaging_depth_o
);
    import acc_pkg::*;

    acc_cfg_if cfg ();

    acc_byte_t   en_q, en_d, cfga_q, cfga_d, cfgc_q, cfgc_d;
    acc_byte_t   avg_q, avg_d, pin_q, pin_d, sw_q, sw_d, link_q, link_d;
    logic        wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic        trig_q, trig_d, stpin_q, stpin_d, divrst_q, divrst_d;
    logic [1:0]  pins_sync;
    logic [6:0]  idx;
    logic        take;

    acc_sync #(
        .W (2)
    ) u_sync (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .async_i({alarm_i, hardware_trigger_pin_i}),
        .sync_o (pins_sync)
    );

    acc_cal_seq #(
        .CW (13)
    ) u_seq (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .cfg    (cfg)
    );

    function automatic acc_byte_t lane_wr(input acc_byte_t old, input logic hit);
        lane_wr = (hit && avs_byteenable_i[0]) ? avs_writedata_i[7:0] : old;
    endfunction

    assign idx  = avs_address_i[8:2];
    // Request is taken at the edge where waitrequest is low
    assign take = !wait_q;

    // Bus handshake and register storage
    always_comb begin
        wait_d  = !((avs_read_i || avs_write_i) && wait_q);
        rdata_d = rdata_q;
        if ((avs_read_i || avs_write_i) && wait_q) begin
            rdata_d = 32'h0;
            case (idx)
                `ACC_IDX_EN:     rdata_d[7:0] = en_q;
                `ACC_IDX_CFG_A:  rdata_d[7:0] = cfga_q;
                `ACC_IDX_CFG_C:  rdata_d[7:0] = cfgc_q;
                `ACC_IDX_AVG:    rdata_d[7:0] = avg_q;
                `ACC_IDX_STATE:  rdata_d[7:0] = {3'h0, cfg.code,
                                                 cfg.stopped, cfg.foreground_done_flag};
                `ACC_IDX_PIN:    rdata_d[7:0] = pin_q;
                `ACC_IDX_SWTRIG: rdata_d[7:0] = sw_q;
                `ACC_IDX_LINK:   rdata_d[7:0] = link_q;
                default:         rdata_d      = 32'h0;
            endcase
        end
        // Whole bytes stored, reserved bits included
        en_d   = lane_wr(en_q,   take && avs_write_i && idx == `ACC_IDX_EN);
        cfga_d = lane_wr(cfga_q, take && avs_write_i && idx == `ACC_IDX_CFG_A);
        cfgc_d = lane_wr(cfgc_q, take && avs_write_i && idx == `ACC_IDX_CFG_C);
        avg_d  = lane_wr(avg_q,  take && avs_write_i && idx == `ACC_IDX_AVG);
        pin_d  = lane_wr(pin_q,  take && avs_write_i && idx == `ACC_IDX_PIN);
        sw_d   = lane_wr(sw_q,   take && avs_write_i && idx == `ACC_IDX_SWTRIG);
        link_d = lane_wr(link_q, take && avs_write_i && idx == `ACC_IDX_LINK);
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
            en_q    <= `ACC_RST_EN;
            cfga_q  <= `ACC_RST_CFG_A;
            cfgc_q  <= `ACC_RST_CFG_C;
            avg_q   <= `ACC_RST_AVG;
            pin_q   <= `ACC_RST_PIN;
            sw_q    <= `ACC_RST_SWTRIG;
            link_q  <= `ACC_RST_LINK;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            en_q    <= en_d;
            cfga_q  <= cfga_d;
            cfgc_q  <= cfgc_d;
            avg_q   <= avg_d;
            pin_q   <= pin_d;
            sw_q    <= sw_d;
            link_q  <= link_d;
        end
    end

    // Trigger, status pin and divider reset
    always_comb begin
        if (pin_q[`ACC_TSRC_BIT])
            trig_d = pins_sync[0];
        else
            trig_d = sw_q[`ACC_SWTRIG_BIT];
        case (pin_q[`ACC_STSEL_HI:`ACC_STSEL_LO])
            `ACC_SEL_FG:    stpin_d = cfg.foreground_done_flag;
            `ACC_SEL_STOP:  stpin_d = cfg.stopped;
            `ACC_SEL_ALARM: stpin_d = pins_sync[1];
            default:        stpin_d = 1'b0;
        endcase
        divrst_d = !en_q[`ACC_EN_BIT];
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            trig_q   <= 1'b0;
            stpin_q  <= 1'b0;
            divrst_q <= 1'b1;
        end else begin
            trig_q   <= trig_d;
            stpin_q  <= stpin_d;
            divrst_q <= divrst_d;
        end
    end

    assign cfg.cal_en   = en_q[`ACC_EN_BIT];
    assign cfg.trig     = trig_q;
    assign cfg.fg_sel   = cfga_q[`ACC_FG_BIT];
    assign cfg.bg_en    = cfga_q[`ACC_BG_BIT];
    assign cfg.os_en    = cfga_q[`ACC_OS_BIT];
    assign cfg.bgos_en  = cfga_q[`ACC_BGOS_BIT];
    // Takes effect at the next enable edge; host keeps the link off meanwhile
    assign cfg.park_sel = cfgc_q[`ACC_PARK_HI:`ACC_PARK_LO];
    assign cfg.offset_averaging_depth   = avg_q[`ACC_OSAVG_HI:`ACC_OSAVG_LO];
    assign cfg.lin_avg  = avg_q[`ACC_LINAVG_HI:`ACC_LINAVG_LO];

    assign avs_readdata_o              = rdata_q;
    assign avs_waitrequest_o           = wait_q;
    assign status_output_pin_o         = stpin_q;
    assign serial_link_enable_o        = link_q[`ACC_LINK_BIT];
    assign divider_reset_o             = divrst_q;
    assign cal_values_reset_o          = cfg.clr_vals;
    assign offset_run_o                = cfg.os_run;
    assign linearity_run_o             = cfg.lin_run;
    assign background_offset_run_o     = cfg.bgos_run;
    assign core_park_o                 = cfg.park;
    assign offset_averaging_depth_o    = cfg.offset_averaging_depth;
    assign linearity_averaging_depth_o = cfg.lin_avg;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence req_s;
        (avs_read_i || avs_write_i) && wait_q;
    endsequence

    bus_answer_a: assert property (req_s |=> !wait_q ##1 wait_q)
        else $error("waitrequest did not drop for one cycle");
    sw_trigger_a: assert property (!pin_q[0] |=> trig_q == $past(sw_q[0]))
        else $error("software trigger not selected");
    hw_trigger_a: assert property (pin_q[0] |=> trig_q == $past(pins_sync[0]))
        else $error("hardware trigger not selected");
    pin_low_a: assert property (pin_q[2:1] == 2'h3 |=> !stpin_q)
        else $error("status pin not low in select three");
    pin_done_a: assert property (pin_q[2:1] == 2'h0 |=> stpin_q == $past(cfg.foreground_done_flag))
        else $error("status pin does not follow done flag");
    div_reset_a: assert property (!en_q[0] |=> divrst_q)
        else $error("dividers not reset while disabled");
    reserved_keep_a: assert property (take && avs_write_i && idx == `ACC_IDX_CFG_A
                                      && avs_byteenable_i[0]
                                      |=> cfga_q == $past(avs_writedata_i[7:0]))
        else $error("reserved bits not stored");
endmodule
`default_nettype wire

// [verification/acc_pin_drv.sv]
`timescale 1ns/1ps
`default_nettype none
module acc_pin_drv (
    // Clock
    input  wire logic mclk_i,
    // Commands from the bench
    input  wire logic trig_cmd_i,
    input  wire logic alarm_cmd_i,
    // Device pins
    output logic      hardware_trigger_pin_o,
    output logic      alarm_o
);
    initial begin
        hardware_trigger_pin_o = 1'b0;
        alarm_o                = 1'b0;
    end

    // Board logic on the same clock: pins move just after an edge
    always @(posedge mclk_i) begin
        hardware_trigger_pin_o <= trig_cmd_i;
        alarm_o                <= alarm_cmd_i;
    end
endmodule
`default_nettype wire

// [verification/tb_acc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_acc_top;
    logic        mclk_i;
    logic        nrst_i;
    logic [8:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        trig_pin;
    logic        alarm_pin;
    logic        trig_cmd;
    logic        alarm_cmd;
    logic        stat_pin;
    logic        link_en;
    logic        div_rst;
    logic        clr_pulse;
    logic        os_run;
    logic        lin_run;
    logic        bgos_run;
    logic [2:0]  park;
    logic [2:0]  offset_averaging_depth;
    logic [2:0]  lin_avg;
    logic [7:0]  rd_v;
    int          n_mismatch;
    int          checked;
    int          n_clr;
    int          n_start;

    acc_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .hardware_trigger_pin_i(trig_pin), .alarm_i(alarm_pin),
        .status_output_pin_o(stat_pin), .serial_link_enable_o(link_en),
        .divider_reset_o(div_rst), .cal_values_reset_o(clr_pulse),
        .offset_run_o(os_run), .linearity_run_o(lin_run), .background_offset_run_o(bgos_run),
        .core_park_o(park), .offset_averaging_depth_o(offset_averaging_depth),
        .linearity_averaging_depth_o(lin_avg));

    acc_pin_drv i_pins (.mclk_i(mclk_i), .trig_cmd_i(trig_cmd), .alarm_cmd_i(alarm_cmd),
        .hardware_trigger_pin_o(trig_pin), .alarm_o(alarm_pin));

    always #5 mclk_i = ~mclk_i;

    // Every calibration start must give exactly one clear pulse
    always @(posedge mclk_i) begin
        if (clr_pulse === 1'b1) begin
            n_clr++;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; the request is held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= {24'h0, wd};
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
        end
        rd_v = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic rchk(input logic [6:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk(what, exp, rd_v);
    endtask

    // Poll the status register for a whole byte, bounded
    task automatic wait_st(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            bus(1'b0, 7'h6A, 8'h00);
            n++;
        end while (rd_v !== exp && n < 800);
        chk("status", exp, rd_v);
    endtask

    // Settings only change while calibration is held
    task automatic cal(input logic [7:0] a, input logic [7:0] c);
        bus(1'b1, 7'h61, 8'h00);
        rchk(7'h6A, 8'h00, "held status");
        chk("divider reset", 8'h01, {7'h0, div_rst});
        bus(1'b1, 7'h62, a);
        bus(1'b1, 7'h64, c);
        bus(1'b1, 7'h61, 8'h01);
        n_start++;
    endtask

    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk_i);
        n_mismatch++;
        end_sim();
    end

    initial begin
        logic [6:0] idx [8];
        logic [7:0] rst [8];
        logic [2:0] pk [4];
        idx = '{7'h61, 7'h62, 7'h64, 7'h68, 7'h6B, 7'h6C, 7'h71, 7'h70};
        rst = '{8'h01, 8'h01, 8'h02, 8'h61, 8'h00, 8'h01, 8'h00, 8'h00};
        pk = '{3'h1, 3'h2, 3'h4, 3'h0};
        {mclk_i, nrst_i, avs_read_i, avs_write_i, trig_cmd, alarm_cmd} = '0;
        {avs_address_i, avs_writedata_i, n_mismatch, checked, n_clr} = '0;
        n_start = 1;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rchk(idx[i], rst[i], "reset value");
        end
        chk("offset depth", 8'h06, {5'h0, offset_averaging_depth});
        chk("linearity depth", 8'h01, {5'h0, lin_avg});
        wait_st(8'h1F);
        alarm_cmd <= 1'b1;
        for (int s = 0; s < 5; s++) begin
            bus(1'b1, 7'h6B, {5'h0, s[1:0] ^ {s[2], 1'b0}, 1'b0});
            alarm_cmd <= (s < 4);
            repeat (6) @(posedge mclk_i);
            chk("status pin", {7'h0, s < 3}, {7'h0, stat_pin});
        end
        bus(1'b1, 7'h71, 8'h01);
        @(posedge mclk_i);
        chk("link enable", 8'h01, {7'h0, link_en});
        bus(1'b1, 7'h71, 8'h00);
        cal(8'hF0, 8'h01);
        rchk(7'h62, 8'hF0, "reserved bits");
        wait_st(8'h1F);
        bus(1'b1, 7'h6C, 8'h00);
        cal(8'h01, 8'h01);
        wait_st(8'h08);
        trig_cmd <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rchk(7'h6A, 8'h08, "pin ignored");
        bus(1'b1, 7'h6C, 8'h01);
        wait_st(8'h1F);
        trig_cmd <= 1'b0;
        bus(1'b1, 7'h6B, 8'h01);
        cal(8'h01, 8'h01);
        wait_st(8'h08);
        trig_cmd <= 1'b1;
        wait_st(8'h1F);
        bus(1'b1, 7'h6B, 8'h00);
        bus(1'b1, 7'h68, 8'h00);
        @(posedge mclk_i);
        chk("offset depth", 8'h00, {5'h0, offset_averaging_depth});
        chk("linearity depth", 8'h00, {5'h0, lin_avg});
        cal(8'h05, 8'h01);
        wait_st(8'h0C);
        chk("offset run", 8'h01, {7'h0, os_run});
        wait_st(8'h1F);
        // Live writes must wait for the next enable rise
        bus(1'b1, 7'h62, 8'h0B);
        rchk(7'h6A, 8'h1F, "live write");
        cal(8'h0B, 8'h01);
        wait_st(8'h15);
        chk("bg offset run", 8'h01, {7'h0, bgos_run});
        chk("linearity run", 8'h01, {7'h0, lin_run});
        chk("park with bg", 8'h00, {5'h0, park});
        bus(1'b1, 7'h6C, 8'h00);
        wait_st(8'h1B);
        bus(1'b1, 7'h6C, 8'h01);
        wait_st(8'h15);
        cal(8'h03, 8'h01);
        wait_st(8'h15);
        chk("bg offset off", 8'h00, {7'h0, bgos_run});
        for (int p = 0; p < 4; p++) begin
            cal(8'h01, p[7:0]);
            wait_st(8'h1F);
            chk("parked core", {5'h0, pk[p]}, {5'h0, park});
        end
        repeat (4) @(posedge mclk_i);
        chk("clear pulses", n_start[7:0], n_clr[7:0]);
        end_sim();
    end
endmodule
`default_nettype wire
